//--- hdl/mbts_edge.sv
// Control word capture with per-bit rising and falling edge pulses.
// Assumes each control word update is marked by a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none

module mbts_edge (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ctrl_valid,
    input wire logic [15:0] ctrl_word,
    output logic [15:0] word_reg,
    output logic [15:0] rise_reg,
    output logic [15:0] fall_reg,
    output logic upd_reg
);

    // Update strobe delayed to line up with the captured word
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= ctrl_valid;
        end
    end

    // Previous value only moves on an update, so each edge pulses once
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    word_reg[i] <= 1'b0;
                    rise_reg[i] <= 1'b0;
                    fall_reg[i] <= 1'b0;
                end else begin
                    rise_reg[i] <= ctrl_valid & ctrl_word[i] & ~word_reg[i];
                    fall_reg[i] <= ctrl_valid & ~ctrl_word[i] & word_reg[i];
                    if (ctrl_valid) begin
                        word_reg[i] <= ctrl_word[i];
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- hdl/mbts_power.sv
// Power-up handshake: walks disabled, ready, switched on, operation enabled.
// Assumes the word and strobe come from mbts_edge, already registered.
`timescale 1ns/1ps
`default_nettype none
`include "mbts_map.svh"

module mbts_power
    import mbts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic upd,
    input wire logic [15:0] word,
    output logic op_enabled,
    output logic [7:0] status_low_reg
);

    mbts_pwr_t pwr_reg;
    mbts_pwr_t pwr_next;
    logic [3:0] nib;

    assign nib = word[3:0];
    assign op_enabled = (pwr_reg == MBTS_PWR_OP_ENABLED);

    // Steps may only be taken in order; a skipped step is ignored
    always_comb begin
        pwr_next = pwr_reg;
        case (nib)
            `MBTS_CW_DISABLE: pwr_next = MBTS_PWR_DISABLED;
            `MBTS_CW_SHUTDOWN: pwr_next = MBTS_PWR_READY;
            `MBTS_CW_SWITCH_ON: begin
                if (pwr_reg != MBTS_PWR_DISABLED) begin
                    pwr_next = MBTS_PWR_SWITCHED_ON;
                end
            end
            `MBTS_CW_ENABLE_OP: begin
                if (pwr_reg == MBTS_PWR_SWITCHED_ON) begin
                    pwr_next = MBTS_PWR_OP_ENABLED;
                end
            end
            default: pwr_next = MBTS_PWR_DISABLED; // Unknown words fall back safe
        endcase
    end

    // State and the matching status answer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_reg <= MBTS_PWR_DISABLED;
            status_low_reg <= `MBTS_SW_DISABLED;
        end else if (upd) begin
            pwr_reg <= pwr_next;
            case (pwr_next)
                MBTS_PWR_READY: status_low_reg <= `MBTS_SW_READY;
                MBTS_PWR_SWITCHED_ON: status_low_reg <= `MBTS_SW_SWITCHED_ON;
                MBTS_PWR_OP_ENABLED: status_low_reg <= `MBTS_SW_OP_ENABLED;
                default: status_low_reg <= `MBTS_SW_DISABLED;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- hdl/mbts_sequencer.sv
// Motion block table sequencer: control word in, status word and block
// numbers out, single block or automatic chains driven on an engine.
// Assumes a trajectory engine that takes go/stop/block and reports done,
// the next-block setting of the finished block and axis feedback levels.
//
// Overview of operation
// - Status bit 8 stays high while a single block or sequence executes.
// - Single motion clears in-progress when the selected block completes.
// - Sequence clears in-progress only at next-block settings 0, -1, -2, -3; the code ends the chain at any setting of 0 or below.
// - Halt low: bit 10 set only for positioning block inside window.
// - Halt high: bit 10 low while decelerating, high at zero speed.
// - Bit 12 follows electronic gear synchronous running.
// - Control bit 4 picks single block (0) or automatic chain (1).
// - Block number computed from select field at start rising edge.
// - Actual block output tracks the block currently executing.
// - Start dropping to 0 while executing decelerates at block ramp.
// - Resume set plus start falling edge continues interrupted work.
// - Resume with no valid interrupted block starts the selected block.
// - Resumable block reads -1 when none valid or not interrupted.
// - Halt stops block at its ramp; halt release continues it.
// - Host walks 0x0000, 0x0006, 0x0007, 0x000F awaiting each status.
// - Start block equals five-bit select field plus one, 1 to 32.
// - Resume bit 1 takes last actual block, 0 takes select field.
`timescale 1ns/1ps
`default_nettype none
`include "mbts_map.svh"

module mbts_sequencer
    import mbts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ctrl_valid,
    input wire logic [15:0] ctrl_word,
    input wire mbts_mfb_t mot_fb,
    output mbts_mcmd_t mot_cmd_reg,
    output logic [15:0] status_word_reg,
    output logic signed [7:0] actual_block_reg,
    output logic signed [7:0] resume_block_reg
);

    logic [15:0] cw;
    logic [15:0] cw_rise;
    logic [15:0] cw_fall;
    logic upd;
    logic op_enabled;
    logic [7:0] status_low;

    mbts_state_t state_reg;
    mbts_state_t state_next;
    logic seq_mode_reg;
    logic seq_mode_next;
    logic signed [7:0] block_next;
    logic go_next;
    logic signed [7:0] resume_next;
    logic signed [7:0] sel_block;
    logic signed [7:0] start_block;
    logic halt;
    logic start_rise;
    logic start_fall;
    logic halt_rise;
    logic halt_fall;
    logic chain_end;
    logic target_next;

    // Control word capture and edge detection
    mbts_edge u_edge (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ctrl_valid(ctrl_valid),
        .ctrl_word(ctrl_word),
        .word_reg(cw),
        .rise_reg(cw_rise),
        .fall_reg(cw_fall),
        .upd_reg(upd)
    );

    // Power-up handshake with the host
    mbts_power u_power (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .upd(upd),
        .word(cw),
        .op_enabled(op_enabled),
        .status_low_reg(status_low)
    );

    // Decoded control bits; motion commands only count once enabled
    assign halt = cw[`MBTS_CW_HALT];
    assign start_rise = cw_rise[`MBTS_CW_START] & op_enabled;
    assign start_fall = cw_fall[`MBTS_CW_START] & op_enabled;
    assign halt_rise = cw_rise[`MBTS_CW_HALT];
    assign halt_fall = cw_fall[`MBTS_CW_HALT];

    // Select field plus one gives blocks 1 to 32
    assign sel_block = $signed({3'h0, cw[`MBTS_CW_SEL_HI:`MBTS_CW_SEL_LO]})
        + `MBTS_BLK_OFFSET;

    // Resume picks the interrupted block if there is one, else the field
    always_comb begin
        start_block = sel_block;
        if (cw[`MBTS_CW_RESUME] && (resume_block_reg != `MBTS_BLK_NONE)) begin
            start_block = resume_block_reg;
        end
    end

    // Any non-positive next-block setting ends the chain; 0 to -3 documented
    assign chain_end = (mot_fb.next_block <= `MBTS_BLK_END);

    // Sequencing decisions
    always_comb begin
        state_next = state_reg;
        seq_mode_next = seq_mode_reg;
        block_next = mot_cmd_reg.block;
        go_next = 1'b0;
        resume_next = resume_block_reg;
        case (state_reg)
            MBTS_IDLE: begin
                if (start_rise) begin
                    state_next = MBTS_RUN;
                    seq_mode_next = cw[`MBTS_CW_SEQ_MODE];
                    block_next = start_block;
                    go_next = 1'b1;
                    resume_next = `MBTS_BLK_NONE;
                end else if (start_fall && cw[`MBTS_CW_RESUME]) begin
                    // Continue interrupted work, or the field when none
                    state_next = MBTS_RUN;
                    block_next = start_block;
                    if (resume_block_reg == `MBTS_BLK_NONE) begin
                        seq_mode_next = cw[`MBTS_CW_SEQ_MODE];
                    end
                    go_next = 1'b1;
                    resume_next = `MBTS_BLK_NONE;
                end
            end
            MBTS_RUN: begin
                if (start_fall) begin
                    state_next = MBTS_STOPPING;
                end else if (halt_rise) begin
                    state_next = MBTS_HALTED;
                end else if (mot_fb.done) begin
                    if (!seq_mode_reg) begin
                        state_next = MBTS_IDLE;
                    end else if (chain_end) begin
                        state_next = MBTS_IDLE;
                    end else begin
                        block_next = mot_fb.next_block;
                        go_next = 1'b1;
                    end
                end
            end
            MBTS_HALTED: begin
                if (start_fall) begin
                    state_next = MBTS_STOPPING;
                end else if (halt_fall) begin
                    state_next = MBTS_RUN;
                    go_next = 1'b1;
                end
            end
            MBTS_STOPPING: begin
                // Interruption is only recorded once the axis stands still
                if (mot_fb.speed_zero) begin
                    state_next = MBTS_IDLE;
                    resume_next = mot_cmd_reg.block;
                end
            end
            default: state_next = MBTS_IDLE;
        endcase
        // Losing operation enabled drops everything without a resume point
        if (!op_enabled) begin
            state_next = MBTS_IDLE;
            go_next = 1'b0;
            resume_next = `MBTS_BLK_NONE;
        end
    end

    // Sequencer state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= MBTS_IDLE;
            seq_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            seq_mode_reg <= seq_mode_next;
        end
    end

    // Engine command; stop holds the axis at the current block's ramp
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mot_cmd_reg <= '0;
        end else begin
            mot_cmd_reg.go <= go_next;
            mot_cmd_reg.block <= block_next;
            mot_cmd_reg.stop <= (state_next == MBTS_HALTED)
                || (state_next == MBTS_STOPPING);
        end
    end

    // Block currently executing, refreshed on every launch
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            actual_block_reg <= `MBTS_BLK_NONE;
        end else if (go_next) begin
            actual_block_reg <= block_next;
        end
    end

    // Resumable block, -1 when nothing was interrupted
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            resume_block_reg <= `MBTS_BLK_NONE;
        end else begin
            resume_block_reg <= resume_next;
        end
    end

    // Target reached meaning depends on halt
    always_comb begin
        if (halt) begin
            target_next = mot_fb.speed_zero;
        end else begin
            target_next = mot_fb.positioning & mot_fb.in_window;
        end
    end

    // Status word assembly; unused bits read as zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_word_reg <= {8'h00, `MBTS_SW_DISABLED};
        end else begin
            status_word_reg <= 16'h0000;
            status_word_reg[7:0] <= status_low;
            status_word_reg[`MBTS_SW_IN_PROGRESS] <= (state_next != MBTS_IDLE);
            status_word_reg[`MBTS_SW_TARGET] <= target_next;
            status_word_reg[`MBTS_SW_IN_GEAR] <= mot_fb.gear_sync;
            status_word_reg[`MBTS_SW_CONTOUR] <= mot_fb.contour_err;
        end
    end

endmodule

`default_nettype wire

//--- pkg/mbts_map.svh
// Constants for the motion block table sequencer: control and status word
// bit positions, power-up handshake words and block numbering.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MBTS_MAP_SVH
`define MBTS_MAP_SVH

// Control word bit positions
`define MBTS_CW_SEQ_MODE 4
`define MBTS_CW_RESUME 6
`define MBTS_CW_HALT 8
`define MBTS_CW_START 9
`define MBTS_CW_SEL_LO 11
`define MBTS_CW_SEL_HI 15

// Control word low nibble for each power-up step
`define MBTS_CW_DISABLE 4'h0
`define MBTS_CW_SHUTDOWN 4'h6
`define MBTS_CW_SWITCH_ON 4'h7
`define MBTS_CW_ENABLE_OP 4'hf

// Status word low byte answered for each power-up step
`define MBTS_SW_DISABLED 8'h50
`define MBTS_SW_READY 8'h31
`define MBTS_SW_SWITCHED_ON 8'h33
`define MBTS_SW_OP_ENABLED 8'h37

// Status word bit positions
`define MBTS_SW_IN_PROGRESS 8
`define MBTS_SW_TARGET 10
`define MBTS_SW_IN_GEAR 12
`define MBTS_SW_CONTOUR 13

// Block numbering: select field plus one, and the no-resume marker
`define MBTS_BLK_OFFSET 8'sh01
`define MBTS_BLK_NONE 8'shff
`define MBTS_BLK_END 8'sh00

`endif

//--- pkg/mbts_pkg.sv
// Types shared by the motion block table sequencer and its helpers.
// Assumes mbts_map.svh is on the include path.
`include "mbts_map.svh"

package mbts_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        MBTS_IDLE,
        MBTS_RUN,
        MBTS_HALTED,
        MBTS_STOPPING
    } mbts_state_t;

    // Power-up handshake states
    typedef enum logic [1:0] {
        MBTS_PWR_DISABLED,
        MBTS_PWR_READY,
        MBTS_PWR_SWITCHED_ON,
        MBTS_PWR_OP_ENABLED
    } mbts_pwr_t;

    // Command to the trajectory engine
    typedef struct packed {
        logic go;
        logic stop;
        logic signed [7:0] block;
    } mbts_mcmd_t;

    // Feedback from the trajectory engine
    typedef struct packed {
        logic done;
        logic signed [7:0] next_block;
        logic speed_zero;
        logic in_window;
        logic positioning;
        logic gear_sync;
        logic contour_err;
    } mbts_mfb_t;

endpackage

//--- tb/mbts_engine_model.sv
// Trajectory engine model facing mbts_sequencer.
// Assumes the bench sets run length, next-block setting and levels.
`timescale 1ns/1ps
`default_nettype none

module mbts_engine_model
    import mbts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire mbts_mcmd_t cmd,
    input wire logic [7:0] run_len,
    input wire logic signed [7:0] nxt,
    input wire logic [3:0] lvl,
    output mbts_mfb_t fb
);
    logic moving_reg;
    logic done_reg;
    logic [7:0] cnt_reg;

    // Go restarts the count; stop brakes in three cycles with no done
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            moving_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else begin
            done_reg <= 1'b0;
            if (cmd.go) begin
                moving_reg <= 1'b1;
                cnt_reg <= run_len;
            end else if (moving_reg) begin
                if (cmd.stop && cnt_reg > 8'h03) begin
                    cnt_reg <= 8'h03;
                end else if (cnt_reg == 8'h01) begin
                    moving_reg <= 1'b0;
                    done_reg <= !cmd.stop;
                end else begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end
        end
    end

    // Next-block setting is only valid with done; otherwise garbage
    assign fb = '{done: done_reg, next_block: done_reg ? nxt : ~nxt,
        speed_zero: !moving_reg, in_window: lvl[3], positioning: lvl[2],
        gear_sync: lvl[1], contour_err: lvl[0]};
endmodule
`default_nettype wire

//--- tb/mbts_properties.sv
// Checker on the sequencer ports.
// Assumes one clock domain; bound onto mbts_sequencer below.
`timescale 1ns/1ps
`default_nettype none

module mbts_properties
    import mbts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ctrl_valid,
    input wire logic [15:0] ctrl_word,
    input wire mbts_mfb_t mot_fb,
    input wire mbts_mcmd_t mot_cmd_reg,
    input wire logic [15:0] status_word_reg
);
    logic halt_reg, st_reg, seq_reg, busy;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Host bits as held after each update; mode is fixed per run
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            halt_reg <= 1'b0;
            st_reg <= 1'b0;
            seq_reg <= 1'b0;
        end else if (ctrl_valid) begin
            halt_reg <= ctrl_word[8];
            st_reg <= ctrl_word[9];
            if (ctrl_word[9] && !st_reg) begin
                seq_reg <= ctrl_word[4];
            end
        end
    end
    assign busy = status_word_reg[8];

    sequence s_fresh;
        ctrl_valid && ctrl_word[9] && !st_reg && !ctrl_word[6] && !busy
            && status_word_reg[7:0] == 8'h37;
    endsequence
    sequence s_done;
        busy && mot_fb.done;
    endsequence

    a_gear_follow: assert property ($past(reset_n, 2) |->
        status_word_reg[12] == $past(mot_fb.gear_sync)) else $error("gear bit wrong");
    a_target_halt: assert property ($past(reset_n, 2) && $past(halt_reg) |->
        status_word_reg[10] == $past(mot_fb.speed_zero)) else $error("halt target wrong");
    a_target_window: assert property ($past(reset_n, 2) && !$past(halt_reg) |->
        status_word_reg[10] == $past(mot_fb.positioning && mot_fb.in_window))
        else $error("window target wrong");
    a_fresh_block: assert property (s_fresh |-> ##2 mot_cmd_reg.go &&
        mot_cmd_reg.block == 8'($past(ctrl_word[15:11], 2)) + 8'h01) else $error("start block");
    a_single_clear: assert property (s_done and !seq_reg |=> !busy)
        else $error("single not cleared");
    a_chain_end: assert property (s_done and seq_reg && mot_fb.next_block <= 8'sh00
        |=> !busy) else $error("chain not ended");
    a_chain_next: assert property (s_done and seq_reg && mot_fb.next_block > 8'sh00
        |=> mot_cmd_reg.go && mot_cmd_reg.block == $past(mot_fb.next_block))
        else $error("chain next wrong");
    a_start_fall_stop: assert property (ctrl_valid && st_reg && !ctrl_word[9]
        && !ctrl_word[6] && busy |-> ##2 mot_cmd_reg.stop) else $error("no stop");
    a_halt_stop: assert property (ctrl_valid && ctrl_word[8] && !halt_reg && busy
        && !mot_cmd_reg.stop |-> ##2 mot_cmd_reg.stop) else $error("no halt stop");
    a_go_once: assert property (mot_cmd_reg.go |=> !mot_cmd_reg.go)
        else $error("go twice");
endmodule

bind mbts_sequencer mbts_properties i_mbts_properties (.ref_clk, .reset_n, .ctrl_valid,
    .ctrl_word, .mot_fb, .mot_cmd_reg, .status_word_reg);
`default_nettype wire

//--- tb/mbts_sequencer_test.sv
// Self-checking bench for mbts_sequencer with the engine model.
// Assumes inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none

module mbts_sequencer_test
    import mbts_pkg::*;
;
    logic ref_clk, reset_n, ctrl_valid;
    logic [15:0] ctrl_word, status_word_reg;
    logic [7:0] run_len;
    logic signed [7:0] nxt, actual_block_reg, resume_block_reg;
    logic [3:0] lvl;
    mbts_mfb_t mot_fb;
    mbts_mcmd_t mot_cmd_reg;
    mbts_mcmd_t cmd_seen;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    mbts_sequencer i_mbts_sequencer (.ref_clk, .reset_n, .ctrl_valid, .ctrl_word, .mot_fb,
        .mot_cmd_reg, .status_word_reg, .actual_block_reg, .resume_block_reg);
    mbts_engine_model i_mbts_engine_model (.ref_clk, .reset_n, .cmd(mot_cmd_reg), .run_len,
        .nxt, .lvl, .fb(mot_fb));

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One update; returns once its answer has landed
    task automatic send(input logic [15:0] w);
        ctrl_valid = 1'b1;
        ctrl_word = w;
        step(1);
        ctrl_valid = 1'b0;
        step(1);
        // Go stands for one cycle only, so the command is caught as it launches
        cmd_seen = mot_cmd_reg;
        step(1);
    endtask
    // Start bit is dropped first so the next word is a clean rise
    task automatic launch(input logic [15:0] w);
        send(16'h000f);
        send(w);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 200 && status_word_reg[8] !== 1'b0; i++) step(1);
        check("in progress", {15'h0000, status_word_reg[8]}, 16'h0000);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic t_power();
        send(16'h0207);
        check("start refused", status_word_reg, 16'h0050);
        send(16'h0000);
        check("disabled", status_word_reg, 16'h0050);
        send(16'h0006);
        check("ready", status_word_reg, 16'h0031);
        send(16'h0007);
        check("switched on", status_word_reg, 16'h0033);
        send(16'h000f);
        check("enabled", status_word_reg, 16'h0037);
        $display("power test done");
    endtask
    task automatic t_single();
        lvl = 4'b1100;
        for (int k = 0; k < 4; k++) begin
            launch({5'(k * 31 / 3), 11'h20f});
            check("busy", {15'h0000, status_word_reg[8]}, 16'h0001);
            check("block", {8'h00, actual_block_reg}, 16'(k * 31 / 3 + 1));
            wait_idle();
            check("target", {15'h0000, status_word_reg[10]}, 16'h0001);
        end
        lvl = 4'b0100;
        step(2);
        check("no window", {15'h0000, status_word_reg[10]}, 16'h0000);
        $display("single test done");
    endtask
    task automatic t_seq();
        for (int k = 0; k < 4; k++) begin
            nxt = 8'sh05;
            launch(16'h1a1f);
            for (int i = 0; i < 100 && actual_block_reg !== 8'sh05; i++) step(1);
            nxt = 8'(-k);
            check("chain block", {8'h00, actual_block_reg}, 16'h0005);
            check("chain busy", {15'h0000, status_word_reg[8]}, 16'h0001);
            wait_idle();
        end
        $display("sequence test done");
    endtask
    task automatic t_interrupt();
        nxt = 8'sh05;
        run_len = 8'h28;
        launch(16'h1a1f);
        send(16'h001f);
        check("stop", {15'h0000, mot_cmd_reg.stop}, 16'h0001);
        wait_idle();
        check("resumable", {8'h00, resume_block_reg}, 16'h0004);
        send(16'h025f);
        nxt = 8'shff;
        check("resume go", {15'h0000, cmd_seen.go}, 16'h0001);
        check("resumed", {8'h00, actual_block_reg}, 16'h0004);
        check("consumed", {8'h00, resume_block_reg}, 16'h00ff);
        wait_idle();
        launch(16'h124f);
        check("no resumable", {8'h00, actual_block_reg}, 16'h0003);
        wait_idle();
        check("still none", {8'h00, resume_block_reg}, 16'h00ff);
        // Start is still high, so this is a falling edge with resume and nothing stored
        send(16'h004f);
        check("fall resume go", {15'h0000, cmd_seen.go}, 16'h0001);
        check("fall resume block", {8'h00, actual_block_reg}, 16'h0001);
        wait_idle();
        $display("interrupt test done");
    endtask
    task automatic t_halt();
        launch(16'h020f);
        send(16'h030f);
        check("halt stop", {15'h0000, mot_cmd_reg.stop}, 16'h0001);
        check("braking", {15'h0000, status_word_reg[10]}, 16'h0000);
        step(5);
        check("halted", {13'h0000, status_word_reg[10:8]}, 16'h0005);
        send(16'h020f);
        check("continue", {14'h0000, cmd_seen.go, cmd_seen.stop}, 16'h0002);
        wait_idle();
        lvl = 4'b0011;
        step(2);
        check("in gear", {14'h0000, status_word_reg[13:12]}, 16'h0003);
        $display("halt and gear test done");
    endtask

    // Free-running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        reset_n = 1'b0;
        ctrl_valid = 1'b0;
        ctrl_word = 16'h0000;
        run_len = 8'h08;
        nxt = 8'sh00;
        lvl = 4'h0;
        step(3);
        reset_n = 1'b1;
        check("reset status", status_word_reg, 16'h0050);
        check("reset resume", {8'h00, resume_block_reg}, 16'h00ff);
        t_power();
        t_single();
        t_seq();
        t_interrupt();
        t_halt();
        summarize();
    end
endmodule
`default_nettype wire
